// ==== fms_queue_status.sv ====
`timescale 1ns/1ps

// Operation
// - Alarm clear works only below 125 C
// - Force bit selects fast filter setting
// - Auth success sets cipher flag, software clears
// - Link state codes idle, tx, wait, rx
// - Code 001 waits for launch bit
// - Tx guard: minimum time, optional field
// - Rx guard: minimum time, optional field
// - One byte port pushes and pops queue
// - Flush resets pointers and overrun flag; a core push into the full queue in that cycle sets overrun
// - Flush bit always reads zero
// - Seven bit fill count tracks bytes
// - Near full when free space at or below threshold
// - Near empty when count at or below threshold
// - Threshold resets to eight bytes
// - Flags compare with less or equal
// - Push into full queue sets overrun
module fms_queue_status
#(
  parameter int DEPTH = fms_pkg::QDEPTH,
  parameter int AW    = fms_pkg::QAW,
  parameter int GW    = fms_pkg::GUARD_W
)
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // Host register port
  input  wire fms_pkg::fms_reg_req_t    reg_req,
  output logic [fms_pkg::DW-1:0]        reg_rdata,
  output logic                          reg_rvalid,
  // Internal push side
  input  wire logic                     core_push_valid,
  input  wire logic [fms_pkg::DW-1:0]   core_push_data,
  output logic                          core_push_ready,
  // Internal pop side
  input  wire logic                     core_pop_valid,
  output logic                          core_pop_ready,
  output logic [fms_pkg::DW-1:0]        core_pop_data,
  output logic                          core_pop_data_valid,
  // Queue status
  output logic [AW:0]                   queue_fill_count,
  output logic                          queue_empty,
  output logic                          near_full_flag,
  output logic                          near_empty_flag,
  output logic                          queue_overrun_error,
  // Link sequencing
  input  wire fms_pkg::fms_link_ev_t    link_ev,
  input  wire logic                     wait_for_field,
  input  wire logic                     rf_field_pin,
  input  wire logic [GW-1:0]            tx_guard_time,
  input  wire logic [GW-1:0]            rx_guard_time,
  output fms_pkg::fms_link_state_t      link_state,
  // Cipher status
  input  wire logic                     card_auth_success,
  output logic                          card_cipher_active,
  // Temperature
  input  wire logic [7:0]               temp_reading,
  output logic                          over_temp_error,
  // Bus input filter
  input  wire logic                     bus_proto_fast,
  output logic                          bus_filter_fast
);
  import fms_pkg::*;

  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // **********************************************************************
  // State
  // **********************************************************************

  logic [AW-1:0]     wr_ptr;
  logic [AW-1:0]     rd_ptr;
  logic [THR_W-1:0]  warn_threshold;
  logic              force_fast;
  logic              field_meta;
  logic              field_sync;
  logic              rd_pend;
  logic [REG_AW-1:0] rd_addr_q;
  logic              core_pop_q;
  logic [DW-1:0]     mem_rd_data;

  logic [CW-1:0]     next_count;
  logic [THR_W-1:0]  next_threshold;
  logic              next_overrun;
  logic              next_cipher;
  logic              next_temp_err;
  logic [DW-1:0]     next_rdata;

  // **********************************************************************
  // Register decode
  // **********************************************************************

  // Address match and strobe qualification; a write beats a read.
  wire host_wr  = reg_req.wr;
  wire host_rd  = reg_req.rd & ~reg_req.wr;
  wire sel_st2  = reg_req.addr == ADDR_STATUS2;
  wire sel_data = reg_req.addr == ADDR_QDATA;
  wire sel_lvl  = reg_req.addr == ADDR_QLEVEL;
  wire sel_thr  = reg_req.addr == ADDR_QTHR;
  wire wr_st2   = host_wr & sel_st2;
  wire wr_thr   = host_wr & sel_thr;

  wire host_push = host_wr & sel_data;
  wire host_pop  = host_rd & sel_data;

  wire flush = host_wr & sel_lvl & reg_req.wdata[LVL_FLUSH_BIT];

  // **********************************************************************
  // Queue control
  // **********************************************************************

  // The host owns the single port in a cycle it uses it.
  assign core_push_ready = ~host_push;
  assign core_pop_ready  = ~host_pop;

  // Push and pop attempts from either side.
  wire push_try = host_push | (core_push_valid & ~host_push);
  wire pop_try  = host_pop | (core_pop_valid & ~host_pop);
  wire [DW-1:0] push_data = host_push ? reg_req.wdata : core_push_data;

  // Fullness from the fill count.
  wire is_full  = queue_fill_count == DEPTH_C;
  wire is_empty = queue_fill_count == '0;

  // Refuse full push and empty pop
  wire do_push = push_try & ~is_full & ~flush;
  wire do_pop  = pop_try & ~is_empty & ~flush;

  wire overrun_set = push_try & is_full;

  always_comb
  begin
    next_count = queue_fill_count;
    if (flush)
      next_count = '0;
    else if (do_push & ~do_pop)
      next_count = queue_fill_count + 1'b1;
    else if (do_pop & ~do_push)
      next_count = queue_fill_count - 1'b1;
  end

  assign next_overrun = overrun_set | (queue_overrun_error & ~flush);

  // Warning threshold keeps its value unless written.
  assign next_threshold = wr_thr ? reg_req.wdata[THR_W-1:0] : warn_threshold;

  // Threshold extended to the count width for comparison.
  wire [CW-1:0] thr_ext  = {{(CW-THR_W){1'b0}}, next_threshold};
  wire [CW-1:0] free_cnt = DEPTH_C - next_count;

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge ref_clk)
  begin
    if (reset | flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Count, overrun flag and threshold registers.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      queue_fill_count    <= '0;
      queue_overrun_error <= 1'b0;
      warn_threshold      <= THR_RESET;
    end
    else
    begin
      queue_fill_count    <= next_count;
      queue_overrun_error <= next_overrun;
      warn_threshold      <= next_threshold;
    end
  end

  // Level flags follow the count in the same cycle.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      near_full_flag  <= 1'b0;
      near_empty_flag <= 1'b1;
      queue_empty     <= 1'b1;
    end
    else
    begin
      near_full_flag  <= free_cnt <= thr_ext;
      near_empty_flag <= next_count <= thr_ext;
      queue_empty     <= next_count == '0;
    end
  end

  // Byte storage with a registered read port.
  fms_queue_mem
  #(
    .DEPTH (DEPTH),
    .AW    (AW)
  )
  u_mem
  (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (do_push),
    .wr_addr (wr_ptr),
    .wr_data (push_data),
    .rd_en   (do_pop),
    .rd_addr (rd_ptr),
    .rd_data (mem_rd_data)
  );

  // Internal pop data is the memory's output register.
  assign core_pop_data = mem_rd_data;

  // Marks the cycle in which an internal pop delivers its byte.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      core_pop_q <= 1'b0;
    else
      core_pop_q <= do_pop & ~host_pop;
  end

  assign core_pop_data_valid = core_pop_q;

  // **********************************************************************
  // Secondary status bits
  // **********************************************************************

  // Auth sets, software write of zero clears
  assign next_cipher = card_auth_success |
                       (card_cipher_active &
                        ~(wr_st2 & ~reg_req.wdata[ST2_CIPH_BIT]));

  // Sensor at or above the limit counts as overheating.
  wire temp_hot = temp_reading >= TEMP_LIMIT_C;

  wire temp_clr = wr_st2 & reg_req.wdata[ST2_TCLR_BIT] & ~temp_hot;

  assign next_temp_err = temp_hot | (over_temp_error & ~temp_clr);

  // Status bit registers and the filter select.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      force_fast         <= 1'b0;
      card_cipher_active <= 1'b0;
      over_temp_error    <= 1'b0;
      bus_filter_fast    <= 1'b0;
    end
    else
    begin
      if (wr_st2)
        force_fast <= reg_req.wdata[ST2_FAST_BIT];
      card_cipher_active <= next_cipher;
      over_temp_error    <= next_temp_err;
      bus_filter_fast    <= force_fast | bus_proto_fast;
    end
  end

  // **********************************************************************
  // Link state
  // **********************************************************************

  // RF field detect arrives from a pin and is synchronised first.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      field_meta <= 1'b0;
      field_sync <= 1'b0;
    end
    else
    begin
      field_meta <= rf_field_pin;
      field_sync <= field_meta;
    end
  end

  // Transmit and receive sequence.
  fms_link_seq
  #(
    .GW (GW)
  )
  u_link
  (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .ev             (link_ev),
    .wait_for_field (wait_for_field),
    .field_present  (field_sync),
    .tx_guard_time  (tx_guard_time),
    .rx_guard_time  (rx_guard_time),
    .link_state     (link_state)
  );

  // **********************************************************************
  // Read path
  // **********************************************************************

  // Reads are answered two edges after the request.
  always_comb
  begin
    next_rdata = DATA_ZERO;
    case (rd_addr_q)
      ADDR_STATUS2:
        next_rdata = {1'b0, force_fast, 2'b00,
                      card_cipher_active, link_state};
      ADDR_QDATA:
        next_rdata = mem_rd_data;
      ADDR_QLEVEL:
        next_rdata = {1'b0, queue_fill_count};
      ADDR_QTHR:
        next_rdata = {2'b00, warn_threshold};
      default:
        next_rdata = DATA_ZERO;
    endcase
  end

  // Request capture stage.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rd_pend   <= 1'b0;
      rd_addr_q <= '0;
    end
    else
    begin
      rd_pend   <= host_rd;
      rd_addr_q <= reg_req.addr;
    end
  end

  // Answer stage; data holds until the next answer.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      reg_rdata  <= DATA_ZERO;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= rd_pend;
      if (rd_pend)
        reg_rdata <= next_rdata;
    end
  end

endmodule

// ==== fms_pkg.sv ====
package fms_pkg;

  // **********************************************************************
  // Register map and field layout
  // **********************************************************************

  // Register port widths.
  localparam int REG_AW = 6;
  localparam int DW     = 8;
  localparam int THR_W  = 6;

  // Register offsets.
  localparam logic [REG_AW-1:0] ADDR_STATUS2 = 6'h08;
  localparam logic [REG_AW-1:0] ADDR_QDATA   = 6'h09;
  localparam logic [REG_AW-1:0] ADDR_QLEVEL  = 6'h0A;
  localparam logic [REG_AW-1:0] ADDR_QTHR    = 6'h0B;

  // Field positions.
  localparam int ST2_TCLR_BIT  = 7;
  localparam int ST2_FAST_BIT  = 6;
  localparam int ST2_CIPH_BIT  = 3;
  localparam int LVL_FLUSH_BIT = 7;

  // Reset values.
  localparam logic [THR_W-1:0] THR_RESET = 6'h08;
  localparam logic [DW-1:0]    DATA_ZERO = 8'h00;

  // Over-temperature alarm limit in degrees C (125).
  localparam logic [7:0] TEMP_LIMIT_C = 8'h7D;

  // Queue geometry and guard counter width.
  localparam int QDEPTH  = 64;
  localparam int QAW     = 6;
  localparam int GUARD_W = 8;

  // **********************************************************************
  // Types
  // **********************************************************************

  // Link state codes as reported in the secondary status register.
  typedef enum logic [2:0]
  {
    LS_IDLE        = 3'h0,
    LS_WAIT_LAUNCH = 3'h1,
    LS_TX_GUARD    = 3'h2,
    LS_TX          = 3'h3,
    LS_RX_GUARD    = 3'h4,
    LS_WAIT_DATA   = 3'h5,
    LS_RX          = 3'h6
  } fms_link_state_t;

  // Host register request.
  typedef struct packed
  {
    logic              wr;
    logic              rd;
    logic [REG_AW-1:0] addr;
    logic [DW-1:0]     wdata;
  } fms_reg_req_t;

  // Events from the transmitter, receiver and command logic.
  typedef struct packed
  {
    logic tx_request;
    logic launch_transmit;
    logic tx_done;
    logic rx_begin;
    logic rx_done;
    logic abort;
  } fms_link_ev_t;

endpackage

// ==== fms_queue_mem.sv ====
`timescale 1ns/1ps

module fms_queue_mem
#(
  parameter int DEPTH = fms_pkg::QDEPTH,
  parameter int AW    = fms_pkg::QAW
)
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // Write side
  input  wire logic                  wr_en,
  input  wire logic [AW-1:0]         wr_addr,
  input  wire logic [fms_pkg::DW-1:0] wr_data,
  // Read side
  input  wire logic                  rd_en,
  input  wire logic [AW-1:0]         rd_addr,
  output logic      [fms_pkg::DW-1:0] rd_data
);
  import fms_pkg::*;

  logic [DW-1:0] mem [DEPTH];

  // Storage array, written without reset.
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Registered read port.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rd_data <= DATA_ZERO;
    else if (rd_en)
      rd_data <= mem[rd_addr];
  end

endmodule

// ==== fms_link_seq.sv ====
`timescale 1ns/1ps

module fms_link_seq
#(
  parameter int GW = fms_pkg::GUARD_W
)
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // Events and options
  input  wire fms_pkg::fms_link_ev_t    ev,
  input  wire logic                     wait_for_field,
  input  wire logic                     field_present,
  input  wire logic [GW-1:0]            tx_guard_time,
  input  wire logic [GW-1:0]            rx_guard_time,
  // State
  output fms_pkg::fms_link_state_t      link_state
);
  import fms_pkg::*;

  fms_link_state_t next_state;
  logic [GW-1:0]   guard_cnt;
  logic [GW-1:0]   next_guard_cnt;

  // Guard exit needs the minimum time spent and, if asked, a field.
  wire             field_ok   = ~wait_for_field | field_present;
  wire [GW-1:0]    guard_min  = (link_state == LS_TX_GUARD) ?
                                tx_guard_time : rx_guard_time;
  wire [GW:0]      guard_spent = {1'b0, guard_cnt} + {{GW{1'b0}}, 1'b1};
  wire             guard_done = (guard_spent >= {1'b0, guard_min}) & field_ok;
  wire             cnt_max    = &guard_cnt;

  // Next state of the combined transmit and receive sequence.
  always_comb
  begin
    next_state = link_state;
    case (link_state)
      LS_IDLE:
        if (ev.tx_request)
          next_state = LS_WAIT_LAUNCH;
      LS_WAIT_LAUNCH:
        if (ev.launch_transmit)
          next_state = LS_TX_GUARD;
      LS_TX_GUARD:
        if (guard_done)
          next_state = LS_TX;
      LS_TX:
        if (ev.tx_done)
          next_state = LS_RX_GUARD;
      LS_RX_GUARD:
        if (guard_done)
          next_state = LS_WAIT_DATA;
      LS_WAIT_DATA:
        if (ev.rx_begin)
          next_state = LS_RX;
      LS_RX:
        if (ev.rx_done)
          next_state = LS_IDLE;
      default:
        next_state = LS_IDLE;
    endcase
    if (ev.abort)
      next_state = LS_IDLE;
  end

  // Guard counter restarts on every state change and saturates.
  assign next_guard_cnt = (next_state != link_state) ? '0 :
                          (cnt_max ? guard_cnt : guard_cnt + 1'b1);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      link_state <= LS_IDLE;
      guard_cnt  <= '0;
    end
    else
    begin
      link_state <= next_state;
      guard_cnt  <= next_guard_cnt;
    end
  end

endmodule

// ==== fms_queue_status_chk.sv ====
`timescale 1ns/1ps

// ****
// Queue and status checker
// ****
module fms_queue_status_chk
#(
  parameter int DEPTH = fms_pkg::QDEPTH,
  parameter int AW    = fms_pkg::QAW
)
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // Host port
  input  wire fms_pkg::fms_reg_req_t    reg_req,
  input  wire logic [fms_pkg::DW-1:0]   reg_rdata,
  input  wire logic                     reg_rvalid,
  // Internal side
  input  wire logic                     core_push_valid,
  input  wire logic                     core_pop_valid,
  input  wire fms_pkg::fms_link_ev_t    link_ev,
  input  wire fms_pkg::fms_link_state_t link_state,
  input  wire logic                     card_auth_success,
  input  wire logic                     card_cipher_active,
  // Queue status
  input  wire logic [AW:0]              queue_fill_count,
  input  wire logic                     near_full_flag,
  input  wire logic                     near_empty_flag,
  input  wire logic                     queue_overrun_error
);
  import fms_pkg::*;

  // Host strobes decoded by target register.
  wire rd_any = reg_req.rd && !reg_req.wr;
  wire q_wr   = reg_req.wr && reg_req.addr == ADDR_QDATA;
  wire q_rd   = rd_any && reg_req.addr == ADDR_QDATA;
  wire l_rd   = rd_any && reg_req.addr == ADDR_QLEVEL;
  wire t_wr   = reg_req.wr && reg_req.addr == ADDR_QTHR;
  wire flush  = reg_req.wr && reg_req.addr == ADDR_QLEVEL &&
                reg_req.wdata[LVL_FLUSH_BIT];

  // Threshold shadow; flags are left alone while a new value settles.
  logic [THR_W-1:0] thr;
  logic [1:0]       settle;
  always_ff @(posedge ref_clk)
  begin
    thr    <= reset ? THR_RESET : (t_wr ? reg_req.wdata[THR_W-1:0] : thr);
    settle <= (reset || t_wr) ? 2'h2 : settle - 2'(settle != 2'h0);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // A read is taken, then answered two edges on.
  sequence rd_take;
    rd_any;
  endsequence
  sequence rd_answer;
    ##2 reg_rvalid;
  endsequence

  read_answer_a: assert property (rd_take |-> rd_answer)
    else $error("read answer not on time");
  flush_reads0_a: assert property (l_rd |-> ##2 !reg_rdata[LVL_FLUSH_BIT])
    else $error("flush bit read back as one");
  fill_bound_a: assert property (queue_fill_count <= DEPTH)
    else $error("fill count above depth");
  push_count_a: assert property (q_wr && !core_pop_valid &&
    queue_fill_count < DEPTH |=> queue_fill_count == $past(queue_fill_count) + 1)
    else $error("push did not add one");
  full_drop_a: assert property (q_wr && !core_pop_valid &&
    queue_fill_count == DEPTH |=> queue_overrun_error && queue_fill_count == DEPTH)
    else $error("full push not refused");
  empty_pop_a: assert property (q_rd && !core_push_valid &&
    queue_fill_count == 0 |=> queue_fill_count == 0)
    else $error("empty pop changed count");
  flush_clear_a: assert property (flush && !core_push_valid |=>
    queue_fill_count == 0 && !queue_overrun_error)
    else $error("flush left data or overrun");
  near_full_a: assert property (settle == 2'h0 |->
    near_full_flag == ((DEPTH - queue_fill_count) <= thr))
    else $error("near full flag wrong");
  near_empty_a: assert property (settle == 2'h0 |->
    near_empty_flag == (queue_fill_count <= thr))
    else $error("near empty flag wrong");
  cipher_set_a: assert property ($rose(card_cipher_active) |->
    $past(card_auth_success))
    else $error("cipher flag set without auth");
  launch_hold_a: assert property (link_state == LS_WAIT_LAUNCH &&
    link_ev == '0 && $past(link_ev) == '0 |=> link_state == LS_WAIT_LAUNCH)
    else $error("left launch wait without launch");
  idle_hold_a: assert property (link_state == LS_IDLE &&
    link_ev == '0 |=> link_state == LS_IDLE)
    else $error("left idle without an event");
endmodule

bind fms_queue_status fms_queue_status_chk #(.DEPTH(DEPTH), .AW(AW)) u_chk
(
  .ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .core_push_valid(core_push_valid), .core_pop_valid(core_pop_valid),
  .link_ev(link_ev), .link_state(link_state),
  .card_auth_success(card_auth_success),
  .card_cipher_active(card_cipher_active),
  .queue_fill_count(queue_fill_count), .near_full_flag(near_full_flag),
  .near_empty_flag(near_empty_flag),
  .queue_overrun_error(queue_overrun_error)
);

// ==== fms_core_model.sv ====
`timescale 1ns/1ps

// ****
// Internal transmitter and receiver side
// ****
module fms_core_model
(
  // Clock
  input  wire logic                   ref_clk,
  // Push and pop sides
  output logic                        core_push_valid,
  output logic [fms_pkg::DW-1:0]      core_push_data,
  input  wire logic                   core_push_ready,
  output logic                        core_pop_valid,
  input  wire logic                   core_pop_ready,
  input  wire logic                   core_pop_data_valid,
  input  wire logic [fms_pkg::DW-1:0] core_pop_data,
  // Link events and field pin
  output fms_pkg::fms_link_ev_t       link_ev,
  output logic                        rf_field_pin
);
  import fms_pkg::*;

  // Idle levels at time zero.
  initial
  begin
    core_push_valid = 1'b0;
    core_push_data  = 8'h00;
    core_pop_valid  = 1'b0;
    link_ev         = '0;
    rf_field_pin    = 1'b0;
  end

  task automatic push(input logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    core_push_valid <= 1'b1;
    core_push_data  <= d;
    ok = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      ok = core_push_ready === 1'b1;
      if (ok) break;
    end
    core_push_valid <= 1'b0;
    core_push_data  <= ~d;
  endtask

  task automatic pop(output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    core_pop_valid <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      if (core_pop_ready === 1'b1) break;
    end
    core_pop_valid <= 1'b0;
    @(posedge ref_clk);
    ok = core_pop_data_valid === 1'b1;
    d  = core_pop_data;
  endtask

  // One-cycle event pulse and field level.
  task automatic ev(input logic [5:0] v);
    @(posedge ref_clk);
    link_ev <= fms_link_ev_t'(v);
    @(posedge ref_clk);
    link_ev <= '0;
  endtask
  task automatic field(input logic v);
    @(posedge ref_clk);
    rf_field_pin <= v;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps

// ****
// Queue and status testbench
// ****
module testbench;
  import fms_pkg::*;

  logic ref_clk = 1'b0;
  logic reset, cpv, cpr, cqv, cqr, cqdv, wff, proto, auth;
  logic rvalid, nfull, nempty, ovr, ciph, terr, ffast, field, qe;
  logic [7:0] cpd, cqd, rdata, txg, rxg, temp, d;
  logic [6:0] fill;
  fms_reg_req_t reg_req;
  fms_link_ev_t lev;
  fms_link_state_t ls;
  int fail_count = 0;
  int check_count = 0;
  int n;
  logic ok;

  // Free-running clock.
  always #5 ref_clk = ~ref_clk;

  fms_queue_status dut
  (
    .ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
    .reg_rdata(rdata), .reg_rvalid(rvalid),
    .core_push_valid(cpv), .core_push_data(cpd), .core_push_ready(cpr),
    .core_pop_valid(cqv), .core_pop_ready(cqr), .core_pop_data(cqd),
    .core_pop_data_valid(cqdv), .queue_fill_count(fill), .queue_empty(qe),
    .near_full_flag(nfull), .near_empty_flag(nempty),
    .queue_overrun_error(ovr), .link_ev(lev), .wait_for_field(wff),
    .rf_field_pin(field), .tx_guard_time(txg), .rx_guard_time(rxg),
    .link_state(ls), .card_auth_success(auth), .card_cipher_active(ciph),
    .temp_reading(temp), .over_temp_error(terr),
    .bus_proto_fast(proto), .bus_filter_fast(ffast)
  );

  fms_core_model u_core
  (
    .ref_clk(ref_clk), .core_push_valid(cpv), .core_push_data(cpd),
    .core_push_ready(cpr), .core_pop_valid(cqv), .core_pop_ready(cqr),
    .core_pop_data_valid(cqdv), .core_pop_data(cqd), .link_ev(lev),
    .rf_field_pin(field)
  );

  // Comparison, verdict and register access.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_req <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    rd_go(a);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      if (rvalid === 1'b1) break;
      if (i == 3)
      begin
        fail_count++;
        end_sim;
      end
    end
    v = rdata;
  endtask
  task automatic rd_go(input logic [5:0] a);
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask
  task automatic wait_ls(input fms_link_state_t c, input int mx);
    n = 0;
    while (ls !== c)
    begin
      @(negedge ref_clk);
      n++;
      if (n > mx)
      begin
        fail_count++;
        end_sim;
      end
    end
  endtask
  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask

  // Main sequence.
  initial
  begin
    reg_req = '0;
    {wff, proto, auth} = 3'h0;
    txg = 8'h05;
    rxg = 8'h03;
    temp = 8'h19;
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADDR_STATUS2, d); chk(d, 8'h00);
    rd(ADDR_QLEVEL, d); chk(d, 8'h00);
    rd(ADDR_QTHR, d); chk(d, 8'h08);
    rd(6'h3F, d); chk(d, 8'h00);
    wr(ADDR_QTHR, 8'hC4); rd(ADDR_QTHR, d); chk(d, 8'h04);
    for (int i = 0; i < 64; i++)
    begin
      wr(ADDR_QDATA, 8'(i + 8'h30));
      @(negedge ref_clk);
      chk(8'(nfull), 8'(63 - i <= 4));
      chk(8'(nempty), 8'(i + 1 <= 4));
    end
    wr(ADDR_QDATA, 8'hEE);
    rd(ADDR_QLEVEL, d); chk(d, 8'h40);
    chk(8'(ovr), 8'h01);
    chk(8'(qe), 8'h00);
    rd(ADDR_QDATA, d); chk(d, 8'h30);
    rd(ADDR_QDATA, d); chk(d, 8'h31);
    rd(ADDR_QLEVEL, d); chk(d, 8'h3E);
    wr(ADDR_QLEVEL, 8'h80); rd(ADDR_QLEVEL, d); chk(d, 8'h00);
    chk(8'(ovr), 8'h00);
    chk(8'(qe), 8'h01);
    rd(ADDR_QDATA, d); rd(ADDR_QLEVEL, d); chk(d, 8'h00);
    u_core.push(8'hA5, ok); chk(8'(ok), 8'h01);
    u_core.push(8'h5A, ok); chk(8'(ok), 8'h01);
    rd(ADDR_QDATA, d); chk(d, 8'hA5);
    rd(ADDR_QDATA, d); chk(d, 8'h5A);
    wr(ADDR_QDATA, 8'h3C); u_core.pop(d, ok); chk(d, 8'h3C);
    chk(8'(ok), 8'h01);
    wr(ADDR_STATUS2, 8'h40); rd(ADDR_STATUS2, d); chk(d, 8'h40);
    chk(8'(ffast), 8'h01);
    wr(ADDR_STATUS2, 8'h00);
    for (int p = 1; p >= 0; p--)
    begin
      @(posedge ref_clk);
      proto <= 1'(p);
      settle; chk(8'(ffast), 8'(p));
    end
    @(posedge ref_clk) auth <= ~auth;
    @(posedge ref_clk) auth <= ~auth;
    wr(ADDR_STATUS2, 8'h08); rd(ADDR_STATUS2, d); chk(d, 8'h08);
    chk(8'(ciph), 8'h01);
    wr(ADDR_STATUS2, 8'h00); rd(ADDR_STATUS2, d); chk(d, 8'h00);
    chk(8'(ciph), 8'h00);
    @(posedge ref_clk) temp <= TEMP_LIMIT_C;
    wr(ADDR_STATUS2, 8'h80); settle; chk(8'(terr), 8'h01);
    @(posedge ref_clk) temp <= temp - 8'h01;
    wr(ADDR_STATUS2, 8'h80); settle; chk(8'(terr), 8'h00);
    u_core.ev(6'h20); wait_ls(LS_WAIT_LAUNCH, 4);
    settle; chk(8'(ls), 8'h01);
    u_core.ev(6'h10); wait_ls(LS_TX_GUARD, 4);
    wait_ls(LS_TX, 20); chk(8'(n >= 5), 8'h01);
    @(posedge ref_clk) wff <= ~wff;
    u_core.ev(6'h08); wait_ls(LS_RX_GUARD, 4);
    repeat (20) @(negedge ref_clk);
    chk(8'(ls), 8'h04);
    u_core.field(1'b1); wait_ls(LS_WAIT_DATA, 12);
    rd(ADDR_STATUS2, d); chk(d, 8'h05);
    u_core.ev(6'h04); wait_ls(LS_RX, 4); chk(8'(ls), 8'h06);
    u_core.ev(6'h02); wait_ls(LS_IDLE, 4); chk(8'(ls), 8'h00);
    u_core.ev(6'h20); wait_ls(LS_WAIT_LAUNCH, 4);
    @(posedge ref_clk) txg <= txg - 8'h04;
    rxg <= rxg + 8'h01;
    u_core.ev(6'h10); wait_ls(LS_TX_GUARD, 4);
    wait_ls(LS_TX, 4); chk(8'(n), 8'h01);
    u_core.ev(6'h08); wait_ls(LS_RX_GUARD, 4);
    wait_ls(LS_WAIT_DATA, 8); chk(8'(n), 8'h04);
    u_core.ev(6'h01); wait_ls(LS_IDLE, 4); chk(8'(ls), 8'h00);
    end_sim;
  end
endmodule
